// >>> verilog/elc_pkg.sv
// constants and types for the line common control register bank
package elc_pkg;
  // register offsets on the parallel host port
  localparam logic [7:0] ELC_OFS_LINE_CTRL_B = 8'h1F;
  localparam logic [7:0] ELC_OFS_SIG_TEST_CTRL = 8'h2F;
  // signaling and test control field positions
  localparam int ELC_STC_FORCE_HI = 7;
  localparam int ELC_STC_FORCE_LO = 6;
  localparam int ELC_STC_READ_SRC = 5;
  localparam int ELC_STC_STATUS_SEL = 4;
  localparam int ELC_STC_SIG_INSERT = 3;
  localparam int ELC_STC_SOFT_RESET = 0;
  // line interface control b field positions
  localparam int ELC_LCB_GAIN_MSB = 6;
  localparam int ELC_LCB_GAIN_LSB = 4;
  localparam int ELC_LCB_RATIO_SEL = 3;
  localparam int ELC_LCB_LOOPBACK = 2;
  localparam int ELC_LCB_TX_SYNC = 0;
  // implemented bits; unused bits are not stored and read as zero
  localparam logic [7:0] ELC_STC_MASK = 8'hF9;
  localparam logic [7:0] ELC_LCB_MASK = 8'h7D;
  localparam logic [7:0] ELC_REG_RESET = 8'h00;
  // monitor gain codes
  localparam logic [2:0] ELC_GAIN_NONE = 3'h0;
  localparam logic [2:0] ELC_GAIN_BOOST = 3'h7;
  // output force modes
  typedef enum logic [1:0] {
    ELC_FORCE_NORMAL = 2'b00,
    ELC_FORCE_HIZ = 2'b01,
    ELC_FORCE_LOW = 2'b10,
    ELC_FORCE_HIGH = 2'b11
  } elc_force_e;
  // line sync modes, sync-interface bit first, transmit sync bit second
  typedef enum logic [1:0] {
    ELC_SYNC_NORMAL = 2'b00,
    ELC_SYNC_TX_ONLY = 2'b01,
    ELC_SYNC_BOTH = 2'b10,
    ELC_SYNC_RX_ONLY = 2'b11
  } elc_sync_e;
endpackage : elc_pkg

// >>> verilog/elc_force_if.sv
// carrier between the register bank and the output force stage
`timescale 1ns/1ps
interface elc_force_if
  import elc_pkg::*;
#(
  parameter int N_OUT = 8
);
  elc_force_e mode;
  logic [N_OUT-1:0] func_out;
  modport drv (output mode, output func_out);
  modport frc (input mode, input func_out);
endinterface : elc_force_if

// >>> verilog/elc_output_force.sv
// output test-mode force stage for the device outputs
`timescale 1ns/1ps
module elc_output_force
  import elc_pkg::*;
#(
  parameter int N_OUT = 8
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  elc_force_if.frc force_if,
  output logic [N_OUT-1:0] pad_out,
  output logic [N_OUT-1:0] pad_oe
);
  typedef struct packed {
    logic [N_OUT-1:0] out_reg;
    logic [N_OUT-1:0] oe_reg;
  } elc_frc_s;

  elc_frc_s st_reg;
  elc_frc_s st_next;

  // per output value and enable from the force mode
  always_comb
  begin
    st_next = st_reg;
    for (int i = 0; i < N_OUT; i++)
    begin
      case (force_if.mode)
        ELC_FORCE_NORMAL:
        begin
          st_next.out_reg[i] = force_if.func_out[i];
          st_next.oe_reg[i] = 1'b1;
        end
        ELC_FORCE_HIZ:
        begin
          st_next.out_reg[i] = 1'b0;
          st_next.oe_reg[i] = 1'b0;
        end
        ELC_FORCE_LOW:
        begin
          st_next.out_reg[i] = 1'b0;
          st_next.oe_reg[i] = 1'b1;
        end
        ELC_FORCE_HIGH:
        begin
          st_next.out_reg[i] = 1'b1;
          st_next.oe_reg[i] = 1'b1;
        end
        default:
        begin
          st_next.out_reg[i] = force_if.func_out[i];
          st_next.oe_reg[i] = 1'b1;
        end
      endcase
    end
  end

  // state register; outputs released low and enabled after reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_reg.out_reg <= '0;
      st_reg.oe_reg <= '1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign pad_out = st_reg.out_reg;
  assign pad_oe = st_reg.oe_reg;
endmodule : elc_output_force

// >>> verilog/elc_line_common_ctrl.sv
// common control register bank for one line port
// Operation
// - the sync-interface bit and the transmit sync bit pick normal, tx-only, both or rx-only sync.
// - the output force field gives normal, high impedance, all low or all high outputs.
// - signaling register reads return receive data when the source bit is 0, transmit when 1.
// - the status select bit makes status two bit two show lost tx clock or signaling change.
// - the insert bit enables signaling insertion from the signaling registers into transmit.
// - writing a 0 to 1 change into the soft reset bit clears every register bit to zero.
// - analog loopback feeds the transmit line back to the receiver and ignores receive pins.
// - the ratio bit picks the 1:2 transformer at 0 and the other ratios with build-out at 1.
// - the monitor gain field gives no boost at 000 and full boost at 111; other codes unused.
`timescale 1ns/1ps
module elc_line_common_ctrl
  import elc_pkg::*;
#(
  parameter int N_OUT = 8
)(
  // clock and synchronous active-low reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // parallel host port, synchronous to ref_clk
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rdata_valid,
  // sync-interface bit held in line interface control a
  input wire logic line_sync_interface_enable,
  // pulse telling every other register of the port to clear
  output logic soft_reset_pulse,
  // line sync controls
  output logic tx_sync_signal_on,
  output logic rx_sync_signal_on,
  // signaling controls
  input wire logic [7:0] rx_signaling_byte,
  input wire logic [7:0] tx_signaling_byte,
  output logic [7:0] signaling_read_byte,
  output logic transmit_signaling_insert_enable,
  // status two bit two source
  input wire logic loss_tx_clock,
  input wire logic signaling_change,
  output logic status_two_bit_two,
  // line loopback path
  input wire logic receive_line_pos,
  input wire logic receive_line_neg,
  input wire logic transmit_line_pos,
  input wire logic transmit_line_neg,
  output logic rx_data_pos,
  output logic rx_data_neg,
  // transformer and monitor gain
  output logic transformer_ratio_select,
  output logic monitor_gain_boost_on,
  // forced device outputs
  input wire logic [N_OUT-1:0] func_out,
  output logic [N_OUT-1:0] pad_out,
  output logic [N_OUT-1:0] pad_oe
);
  typedef struct packed {
    // host-visible control registers
    logic [7:0] sig_test_ctrl_reg;
    logic [7:0] line_ctrl_b_reg;
    // registered host answers and the soft reset pulse
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic soft_reset_reg;
    // decoded sync, signaling and status controls
    logic tx_sync_reg;
    logic rx_sync_reg;
    logic [7:0] sig_read_reg;
    logic insert_reg;
    logic status_bit_reg;
    // receive pin synchronisers and agree filters
    logic [2:0] pos_sync_reg;
    logic [2:0] neg_sync_reg;
    logic pos_filt_reg;
    logic neg_filt_reg;
    // receive data and line controls
    logic rx_pos_reg;
    logic rx_neg_reg;
    logic ratio_reg;
    logic boost_reg;
  } elc_state_s;

  // registered state and its next value
  elc_state_s st_reg;
  elc_state_s st_next;
  // decoded sync mode and write strobes
  elc_sync_e sync_mode;
  logic wr_stc;
  logic wr_lcb;
  logic soft_reset_now;

  // carrier to the output force stage
  elc_force_if #(.N_OUT(N_OUT)) force_if ();

  // host write strobe aimed at one register offset
  function automatic logic elc_wr_hit(
    input logic wr,
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    return wr && (addr == ofs);
  endfunction : elc_wr_hit

  // register read decode, unmapped offsets read zero
  function automatic logic [7:0] elc_read_mux(
    input logic [7:0] addr,
    input logic [7:0] stc,
    input logic [7:0] lcb
  );
    logic [7:0] val;
    case (addr)
      ELC_OFS_SIG_TEST_CTRL:
      begin
        val = stc & ELC_STC_MASK;
      end
      ELC_OFS_LINE_CTRL_B:
      begin
        val = lcb & ELC_LCB_MASK;
      end
      default:
      begin
        val = 8'h00;
      end
    endcase
    return val;
  endfunction : elc_read_mux

  // accept a pin level once sync stages two and three agree, else hold the old one
  function automatic logic elc_pin_filter(
    input logic [2:0] stages,
    input logic held
  );
    logic lvl;
    lvl = held;
    if (stages[1] == stages[2])
    begin
      lvl = stages[2];
    end
    return lvl;
  endfunction : elc_pin_filter

  // line sync mode, sync-interface bit first, transmit sync bit second
  function automatic elc_sync_e elc_sync_mode(
    input logic sync_if_bit,
    input logic [7:0] lcb
  );
    return elc_sync_e'({sync_if_bit, lcb[ELC_LCB_TX_SYNC]});
  endfunction : elc_sync_mode

  // only the full gain code boosts; the unused codes give no boost
  function automatic logic elc_gain_boost(
    input logic [7:0] lcb
  );
    return lcb[ELC_LCB_GAIN_MSB:ELC_LCB_GAIN_LSB] == ELC_GAIN_BOOST;
  endfunction : elc_gain_boost

  // output force mode from the two force bits
  function automatic elc_force_e elc_force_mode(
    input logic [7:0] stc
  );
    return elc_force_e'({stc[ELC_STC_FORCE_HI], stc[ELC_STC_FORCE_LO]});
  endfunction : elc_force_mode

  // write decode and soft reset edge detection
  assign wr_stc = elc_wr_hit(host_wr, host_addr, ELC_OFS_SIG_TEST_CTRL);
  assign wr_lcb = elc_wr_hit(host_wr, host_addr, ELC_OFS_LINE_CTRL_B);
  assign soft_reset_now = wr_stc && host_wdata[ELC_STC_SOFT_RESET]
    && !st_reg.sig_test_ctrl_reg[ELC_STC_SOFT_RESET];
  assign sync_mode = elc_sync_mode(line_sync_interface_enable, st_reg.line_ctrl_b_reg);

  // next state of the bank and its decoded controls
  always_comb
  begin
    // hold every field unless updated below
    st_next = st_reg;
    // host writes store implemented bits only
    if (wr_stc)
    begin
      st_next.sig_test_ctrl_reg = host_wdata & ELC_STC_MASK;
    end
    if (wr_lcb)
    begin
      st_next.line_ctrl_b_reg = host_wdata & ELC_LCB_MASK;
    end
    // a rising soft reset bit clears all register bits, itself included
    if (soft_reset_now)
    begin
      st_next.sig_test_ctrl_reg = ELC_REG_RESET;
      st_next.line_ctrl_b_reg = ELC_REG_RESET;
    end
    // one-cycle pulse that clears the other registers of the port
    st_next.soft_reset_reg = soft_reset_now;
    // read data one cycle after the read strobe
    st_next.rvalid_reg = host_rd;
    if (host_rd)
    begin
      st_next.rdata_reg = elc_read_mux(host_addr, st_reg.sig_test_ctrl_reg,
        st_reg.line_ctrl_b_reg);
    end
    // line sync mode decode
    case (sync_mode)
      ELC_SYNC_NORMAL:
      begin
        st_next.tx_sync_reg = 1'b0;
        st_next.rx_sync_reg = 1'b0;
      end
      ELC_SYNC_TX_ONLY:
      begin
        st_next.tx_sync_reg = 1'b1;
        st_next.rx_sync_reg = 1'b0;
      end
      ELC_SYNC_BOTH:
      begin
        st_next.tx_sync_reg = 1'b1;
        st_next.rx_sync_reg = 1'b1;
      end
      ELC_SYNC_RX_ONLY:
      begin
        st_next.tx_sync_reg = 1'b0;
        st_next.rx_sync_reg = 1'b1;
      end
      default:
      begin
        st_next.tx_sync_reg = 1'b0;
        st_next.rx_sync_reg = 1'b0;
      end
    endcase
    // signaling read source and transmit insertion
    st_next.sig_read_reg = st_reg.sig_test_ctrl_reg[ELC_STC_READ_SRC]
      ? tx_signaling_byte : rx_signaling_byte;
    st_next.insert_reg = st_reg.sig_test_ctrl_reg[ELC_STC_SIG_INSERT];
    // status two bit two meaning
    st_next.status_bit_reg = st_reg.sig_test_ctrl_reg[ELC_STC_STATUS_SEL]
      ? signaling_change : loss_tx_clock;
    // receive pins: three stages, accept a level once stages two and three agree
    st_next.pos_sync_reg = {st_reg.pos_sync_reg[1:0], receive_line_pos};
    st_next.neg_sync_reg = {st_reg.neg_sync_reg[1:0], receive_line_neg};
    st_next.pos_filt_reg = elc_pin_filter(st_reg.pos_sync_reg, st_reg.pos_filt_reg);
    st_next.neg_filt_reg = elc_pin_filter(st_reg.neg_sync_reg, st_reg.neg_filt_reg);
    // analog loopback replaces the receive pins with the transmit line
    if (st_reg.line_ctrl_b_reg[ELC_LCB_LOOPBACK])
    begin
      st_next.rx_pos_reg = transmit_line_pos;
      st_next.rx_neg_reg = transmit_line_neg;
    end
    else
    begin
      st_next.rx_pos_reg = st_reg.pos_filt_reg;
      st_next.rx_neg_reg = st_reg.neg_filt_reg;
    end
    // transformer ratio and monitor gain
    st_next.ratio_reg = st_reg.line_ctrl_b_reg[ELC_LCB_RATIO_SEL];
    st_next.boost_reg = elc_gain_boost(st_reg.line_ctrl_b_reg);
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      // every field clears, controls and pin stages alike
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // force stage inputs
  assign force_if.mode = elc_force_mode(st_reg.sig_test_ctrl_reg);
  assign force_if.func_out = func_out;

  // output force stage
  elc_output_force #(.N_OUT(N_OUT)) u_force (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .force_if(force_if.frc),
    .pad_out(pad_out),
    .pad_oe(pad_oe)
  );

  // registered host answers and soft reset pulse, straight from the state register
  assign host_rdata = st_reg.rdata_reg;
  assign host_rdata_valid = st_reg.rvalid_reg;
  assign soft_reset_pulse = st_reg.soft_reset_reg;

  // line sync controls
  assign tx_sync_signal_on = st_reg.tx_sync_reg;
  assign rx_sync_signal_on = st_reg.rx_sync_reg;

  // signaling and status outputs
  assign signaling_read_byte = st_reg.sig_read_reg;
  assign transmit_signaling_insert_enable = st_reg.insert_reg;
  assign status_two_bit_two = st_reg.status_bit_reg;

  // receive data and line controls
  assign rx_data_pos = st_reg.rx_pos_reg;
  assign rx_data_neg = st_reg.rx_neg_reg;
  assign transformer_ratio_select = st_reg.ratio_reg;
  assign monitor_gain_boost_on = st_reg.boost_reg;
endmodule : elc_line_common_ctrl

// >>> test/elc_line_common_ctrl_props.sv
// assertion checker for the line common control register bank
`timescale 1ns/1ps
module elc_line_common_ctrl_props
  import elc_pkg::*;
#(
  parameter int N_OUT = 8
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  input wire logic host_rdata_valid,
  input wire logic line_sync_interface_enable,
  input wire logic soft_reset_pulse,
  input wire logic tx_sync_signal_on,
  input wire logic transmit_signaling_insert_enable,
  input wire logic transformer_ratio_select,
  input wire logic monitor_gain_boost_on,
  input wire logic [N_OUT-1:0] pad_out,
  input wire logic [N_OUT-1:0] pad_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // decoded host writes to each register
  logic w_stc;
  logic w_lcb;
  assign w_stc = host_wr && (host_addr == ELC_OFS_SIG_TEST_CTRL);
  assign w_lcb = host_wr && (host_addr == ELC_OFS_LINE_CTRL_B);
  // read handshake
  a_rd_valid_pulse: assert property (host_rd |=> host_rdata_valid)
    else $error("read gave no valid pulse");
  a_no_stray_valid: assert property (!host_rd |=> !host_rdata_valid)
    else $error("valid without a read");
  // control outputs two cycles after the write
  a_insert_follows: assert property (w_stc && !host_wdata[0] |=> ##1
    transmit_signaling_insert_enable == $past(host_wdata[3], 2))
    else $error("insert enable wrong");
  a_ratio_follows: assert property (w_lcb |=> ##1
    transformer_ratio_select == $past(host_wdata[3], 2))
    else $error("ratio select wrong");
  a_gain_full_code: assert property (w_lcb |=> ##1
    monitor_gain_boost_on == ($past(host_wdata[6:4], 2) == 3'h7))
    else $error("gain boost wrong");
  a_tx_sync_mode: assert property (w_lcb |=> ##1
    tx_sync_signal_on == ($past(line_sync_interface_enable) ^ $past(host_wdata[0], 2)))
    else $error("tx sync mode wrong");
  a_force_low_mode: assert property (w_stc && !host_wdata[0] && host_wdata[7:6] == 2'h2
    |=> ##1 (pad_out == '0 && pad_oe == '1))
    else $error("outputs not forced low");
  // soft reset pulse and its cause
  a_soft_reset_pulse: assert property (w_stc && host_wdata[0] |=> soft_reset_pulse)
    else $error("no soft reset pulse");
  a_pulse_has_cause: assert property (soft_reset_pulse |-> $past(w_stc && host_wdata[0]))
    else $error("soft reset pulse without write");
  c_soft_reset: cover property (soft_reset_pulse);
  c_loopback: cover property (w_lcb && host_wdata[2]);
  c_hiz: cover property (w_stc && host_wdata[7:6] == 2'h1);
endmodule : elc_line_common_ctrl_props

bind elc_line_common_ctrl elc_line_common_ctrl_props #(.N_OUT(N_OUT)) u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .host_addr(host_addr), .host_wr(host_wr),
  .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata_valid(host_rdata_valid),
  .line_sync_interface_enable(line_sync_interface_enable),
  .soft_reset_pulse(soft_reset_pulse), .tx_sync_signal_on(tx_sync_signal_on),
  .transmit_signaling_insert_enable(transmit_signaling_insert_enable),
  .transformer_ratio_select(transformer_ratio_select),
  .monitor_gain_boost_on(monitor_gain_boost_on), .pad_out(pad_out), .pad_oe(pad_oe)
);

// >>> test/tb.sv
// self-checking testbench for the line common control register bank
`timescale 1ns/1ps
module tb;
  import elc_pkg::*;
  logic ref_clk = 0, rst_n = 0, host_wr = 0, host_rd = 0, host_rdata_valid;
  logic [7:0] host_addr = 0, host_wdata = 0, host_rdata, signaling_read_byte;
  logic [7:0] rx_signaling_byte = 8'h3C, tx_signaling_byte = 8'hC3, func_out = 8'hA5;
  logic [7:0] pad_out, pad_oe;
  logic line_sync_interface_enable = 0, loss_tx_clock = 1, signaling_change = 0;
  logic receive_line_pos = 0, receive_line_neg = 1, transmit_line_pos = 0;
  logic transmit_line_neg = 0, soft_reset_pulse, tx_sync_signal_on, rx_sync_signal_on;
  logic transmit_signaling_insert_enable, status_two_bit_two, rx_data_pos, rx_data_neg;
  logic transformer_ratio_select, monitor_gain_boost_on;
  int err_count = 0, checks_done = 0;
  elc_line_common_ctrl u_elc_line_common_ctrl (
    .ref_clk(ref_clk), .rst_n(rst_n), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rdata_valid(host_rdata_valid),
    .line_sync_interface_enable(line_sync_interface_enable),
    .soft_reset_pulse(soft_reset_pulse), .tx_sync_signal_on(tx_sync_signal_on),
    .rx_sync_signal_on(rx_sync_signal_on), .rx_signaling_byte(rx_signaling_byte),
    .tx_signaling_byte(tx_signaling_byte), .signaling_read_byte(signaling_read_byte),
    .transmit_signaling_insert_enable(transmit_signaling_insert_enable),
    .loss_tx_clock(loss_tx_clock), .signaling_change(signaling_change),
    .status_two_bit_two(status_two_bit_two), .receive_line_pos(receive_line_pos),
    .receive_line_neg(receive_line_neg), .transmit_line_pos(transmit_line_pos),
    .transmit_line_neg(transmit_line_neg), .rx_data_pos(rx_data_pos),
    .rx_data_neg(rx_data_neg), .transformer_ratio_select(transformer_ratio_select),
    .monitor_gain_boost_on(monitor_gain_boost_on), .func_out(func_out),
    .pad_out(pad_out), .pad_oe(pad_oe)
  );
  // clock
  always #2 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    host_wr = 1;
    host_addr = a;
    host_wdata = d;
    @(negedge ref_clk);
    host_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    host_rd = 1;
    host_addr = a;
    @(negedge ref_clk);
    host_rd = 0;
    chk(host_rdata_valid, 1);
    chk(host_rdata, exp);
  endtask : rd
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_n
  // reset values, readback of implemented bits only written and unmapped offset
  task automatic t_regs;
    rd(ELC_OFS_SIG_TEST_CTRL, 8'h00);
    rd(ELC_OFS_LINE_CTRL_B, 8'h00);
    chk(pad_out, 8'hA5);
    wr(ELC_OFS_SIG_TEST_CTRL, 8'h38);
    rd(ELC_OFS_SIG_TEST_CTRL, 8'h38);
    wr(ELC_OFS_LINE_CTRL_B, 8'h7C);
    rd(ELC_OFS_LINE_CTRL_B, 8'h7C);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
  endtask : t_regs
  // all four sync modes
  task automatic t_sync;
    for (int i = 0; i < 4; i++)
    begin
      line_sync_interface_enable = i[1];
      wr(ELC_OFS_LINE_CTRL_B, {7'h0, i[0]});
      wait_n(3);
      chk(tx_sync_signal_on, (i == 1 || i == 2));
      chk(rx_sync_signal_on, (i >= 2));
    end
  endtask : t_sync
  // all four output force modes
  task automatic t_force;
    logic [7:0] eo[4] = '{8'hA5, 8'hA5, 8'h00, 8'hFF};
    for (int m = 0; m < 4; m++)
    begin
      wr(ELC_OFS_SIG_TEST_CTRL, {m[1:0], 6'h0});
      wait_n(3);
      chk(pad_oe, (m == 1) ? 8'h00 : 8'hFF);
      if (m != 1)
        chk(pad_out, eo[m]);
    end
  endtask : t_force
  // signaling read source, status meaning and insertion
  task automatic t_sig;
    wr(ELC_OFS_SIG_TEST_CTRL, 8'h00);
    wait_n(3);
    chk(signaling_read_byte, 8'h3C);
    chk(status_two_bit_two, 1);
    chk(transmit_signaling_insert_enable, 0);
    wr(ELC_OFS_SIG_TEST_CTRL, 8'h38);
    wait_n(3);
    chk(signaling_read_byte, 8'hC3);
    chk(status_two_bit_two, 0);
    chk(transmit_signaling_insert_enable, 1);
  endtask : t_sig
  // loopback, ratio and gain boost
  task automatic t_line;
    wr(ELC_OFS_LINE_CTRL_B, 8'h7C);
    transmit_line_pos = 1;
    wait_n(3);
    chk(monitor_gain_boost_on, 1);
    chk(transformer_ratio_select, 1);
    chk({rx_data_pos, rx_data_neg}, 2'b10);
    transmit_line_pos = 0;
    transmit_line_neg = 1;
    receive_line_pos = 1;
    receive_line_neg = 0;
    wait_n(2);
    chk({rx_data_pos, rx_data_neg}, 2'b01);
    transmit_line_neg = 0;
    wr(ELC_OFS_LINE_CTRL_B, 8'h30);
    wait_n(8);
    chk(monitor_gain_boost_on, 0);
    chk(transformer_ratio_select, 0);
    chk({rx_data_pos, rx_data_neg}, 2'b10);
  endtask : t_line
  // soft reset clears both registers, and triggers again
  task automatic t_soft;
    wr(ELC_OFS_LINE_CTRL_B, 8'h7C);
    wr(ELC_OFS_SIG_TEST_CTRL, 8'hF9);
    chk(soft_reset_pulse, 1);
    wait_n(2);
    chk(soft_reset_pulse, 0);
    chk(monitor_gain_boost_on, 0);
    rd(ELC_OFS_SIG_TEST_CTRL, 8'h00);
    rd(ELC_OFS_LINE_CTRL_B, 8'h00);
    wr(ELC_OFS_SIG_TEST_CTRL, 8'h01);
    chk(soft_reset_pulse, 1);
  endtask : t_soft
  task automatic wrap_up;
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // main sequence
  initial
  begin
    wait_n(4);
    rst_n = 1;
    t_regs;
    t_sync;
    t_force;
    t_sig;
    t_line;
    t_soft;
    wait_n(4);
    wrap_up;
  end
  // watchdog
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    wrap_up;
  end
endmodule : tb
